// ===== rtl/cache_defs.svh
// constants of the set associative cpu buffer cache
// assumes a 32-bit storage address whose bit 0 is the most significant
`ifndef CACHE_DEFS_SVH
`define CACHE_DEFS_SVH

`define ADDR_W   32     // storage address width
`define TAG_W    21     // address bits 0-20 kept in the address array
`define TAG_HI   31
`define TAG_LO   11
`define COL_W    6      // 64 columns
`define COL_HI   10     // address bits 21-26 pick the column
`define COL_LO   5
`define DW_HI    4      // address bits 27-28 pick a doubleword in a block
`define DW_LO    3
`define BLK_LO   5      // blocks are 32 bytes on a 32-byte boundary
`define COLS     64
`define WAYS     8      // blocks per column in the 16K size
`define WAYS_8K  4      // blocks per column in the 8K size
`define WAY_W    3
`define DW_W     2
`define LAST_DW  2'h3   // fourth doubleword of a block
`define AGE_W    3
// way n starts at age n, so the ages of a column always form a strict order
`define AGE_INIT {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}
`define DATA_W   64
`define BE_W     8
`define IDX_W    11     // column, way and doubleword of a data entry
`define HIT_CYC  2      // request accepted to hit data, in clocks

`endif

// ===== rtl/cache_pkg.sv
// types shared by the buffer cache and its tag comparator
// assumes cache_defs.svh for all widths
`include "cache_defs.svh"
package cache_pkg;
  typedef enum {ST_RUN, ST_FILL, ST_STORE} state_t;   // control states
  typedef logic [`TAG_W-1:0] tag_t;
  typedef logic [`COL_W-1:0] col_t;
  typedef logic [`WAY_W-1:0] way_t;
  typedef logic [`DW_W-1:0]  dw_t;
  typedef struct packed {
    logic                we;      // store when set, fetch when clear
    logic [`ADDR_W-1:0]  addr;
    logic [`DATA_W-1:0]  wdata;
    logic [`BE_W-1:0]    be;
  } req_t;
endpackage

// ===== rtl/lookup_if.sv
// one address array lookup: column contents in, hit and way out
// assumes the owner drives the column contents combinationally
`timescale 1ns/1ps
`include "cache_defs.svh"
interface lookup_if;
  import cache_pkg::*;
  tag_t                           tag;    // tag of the looked-up address
  logic [`WAYS-1:0][`TAG_W-1:0]   tags;   // address array column
  logic [`WAYS-1:0]               valid;  // valid bits of the column
  logic [`WAYS-1:0]               en;     // ways allowed to hit
  logic                           hit;
  way_t                           way;    // hitting way, 0 on miss
  modport unit (input tag, tags, valid, en, output hit, way);
  modport user (output tag, tags, valid, en, input hit, way);
endinterface

// ===== rtl/tag_match.sv
// address array comparator for one column
// assumes at most one valid way holds a given tag
`timescale 1ns/1ps
`include "cache_defs.svh"
module tag_match
  import cache_pkg::*;
(
  lookup_if.unit lk
);

  logic [`WAYS-1:0] hit_v;   // per-way match

  ////////////////////////////////////////////////////////////////////////
  // compare every way at once
  genvar w;
  generate
    for (w = 0; w < `WAYS; w++) begin : g_way
      assign hit_v[w] = lk.valid[w] && lk.en[w] &&
                        (lk.tags[w] == lk.tag);
    end
  endgenerate

  assign lk.hit = |hit_v;

  ////////////////////////////////////////////////////////////////////////
  // encode the matching way, lowest index first
  always_comb begin
    lk.way = '0;
    for (int i = `WAYS - 1; i >= 0; i--) begin
      if (hit_v[i]) begin
        lk.way = way_t'(i);
      end
    end
  end

endmodule

// ===== rtl/buffer_cache.sv
// write-through set associative buffer between cpu and processor storage
// assumes a storage controller that acks each doubleword request once
// Operation
// - hit data two cycles after accept, pipelined
// - fetch hit served from cache, no storage
// - fetch miss reads storage, forwards, fills block
// - stores always write storage, update hits
// - channel store invalidates a resident block
// - channel data bypasses cache entirely
// - disable input sends fetches to storage
// - disabled rows never hit nor allocate
// - 8K size: 64 columns of four blocks
// - block is 32 aligned bytes
// - valid bit per block, program reset clears
// - 8K has four rows, row n is way n
// - 16K has eight blocks per column
// - index uses only address bits 21-31
// - bits 21-26 select the column
// - block may go in any column way
// - address array tags compared for hit
// - replacement is least recently used
`timescale 1ns/1ps
`include "cache_defs.svh"
module buffer_cache
  import cache_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                ipl_reset,   // initial program reset
  input  wire logic                size_16k,    // eight ways when set
  input  wire logic                cache_off,   // global disable
  input  wire logic [`WAYS-1:0]    row_off,     // per-row disable
  input  wire logic                cpu_req,
  input  wire logic                cpu_we,
  input  wire logic [`ADDR_W-1:0]  cpu_addr,
  input  wire logic [`DATA_W-1:0]  cpu_wdata,
  input  wire logic [`BE_W-1:0]    cpu_be,
  output logic                     cpu_ready,
  output logic                     cpu_rvalid,
  output logic [`DATA_W-1:0]       cpu_rdata,
  output logic                     mem_req,
  output logic                     mem_we,
  output logic [`ADDR_W-1:0]       mem_addr,
  output logic [`DATA_W-1:0]       mem_wdata,
  output logic [`BE_W-1:0]         mem_be,
  input  wire logic                mem_ack,
  input  wire logic [`DATA_W-1:0]  mem_rdata,
  input  wire logic                chan_st,     // channel stored a dword
  input  wire logic [`ADDR_W-1:0]  chan_addr
);

  ////////////////////////////////////////////////////////////////////////
  // storage
  logic [`DATA_W-1:0]             data_mem [2**`IDX_W];
  logic [`WAYS-1:0][`TAG_W-1:0]   tag_mem  [`COLS];      // address array
  logic [`WAYS-1:0]               valid_r  [`COLS];
  logic [`WAYS-1:0][`AGE_W-1:0]   age_r    [`COLS];      // lru ages

  // control registers
  state_t              state_r;
  req_t                s1_r;        // request under lookup or service
  logic                s1_v_r;
  req_t                sk_r;        // request taken as service began
  logic                sk_v_r;
  logic                alloc_r;     // the fill keeps its block
  way_t                fill_way_r;  // victim being filled
  dw_t                 dw_cnt_r;    // doubleword being fetched
  logic                stale_r;     // channel hit the block mid-fill
  logic                cpu_ready_r;
  logic                cpu_rvalid_r;
  logic [`DATA_W-1:0]  cpu_rdata_r;
  logic                mem_req_r;
  logic                mem_we_r;
  logic [`ADDR_W-1:0]  mem_addr_r;
  logic [`DATA_W-1:0]  mem_wdata_r;
  logic [`BE_W-1:0]    mem_be_r;

  ////////////////////////////////////////////////////////////////////////
  // address fields; only bits 21-31 index, so lookup overlaps translation
  wire col_t  s1_col = s1_r.addr[`COL_HI:`COL_LO];
  wire tag_t  s1_tag = s1_r.addr[`TAG_HI:`TAG_LO];
  wire dw_t   s1_dw  = s1_r.addr[`DW_HI:`DW_LO];
  wire col_t  ch_col = chan_addr[`COL_HI:`COL_LO];
  wire tag_t  ch_tag = chan_addr[`TAG_HI:`TAG_LO];
  wire req_t  in_req = {cpu_we, cpu_addr, cpu_wdata, cpu_be};

  ////////////////////////////////////////////////////////////////////////
  // row enables: the 8K size leaves the upper four rows unused
  logic [`WAYS-1:0] way_en;
  genvar w;
  generate
    for (w = 0; w < `WAYS; w++) begin : g_en
      assign way_en[w] = !row_off[w] &&
                         (size_16k || w < `WAYS_8K);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // two lookups: the cpu request and the channel store address
  lookup_if cpu_lk ();
  lookup_if ch_lk ();

  assign cpu_lk.tag   = s1_tag;
  assign cpu_lk.tags  = tag_mem[s1_col];
  assign cpu_lk.valid = valid_r[s1_col];
  assign cpu_lk.en    = way_en;
  // channel data never enters the cache; only its address is looked up
  assign ch_lk.tag    = ch_tag;
  assign ch_lk.tags   = tag_mem[ch_col];
  assign ch_lk.valid  = valid_r[ch_col];
  // disabled rows are invalidated too, so re-enabling them stays coherent
  assign ch_lk.en     = {`WAYS{1'b1}};

  tag_match u_cpu_match (.lk(cpu_lk));
  tag_match u_ch_match  (.lk(ch_lk));

  ////////////////////////////////////////////////////////////////////////
  // victim: first free enabled way, else the oldest enabled way
  function automatic way_t pick_victim(
    input logic [`WAYS-1:0]             en,
    input logic [`WAYS-1:0]             v,
    input logic [`WAYS-1:0][`AGE_W-1:0] age);
    way_t             best;
    logic [`AGE_W-1:0] best_age;
    logic             found;
    best = '0;
    best_age = '0;
    found = 1'b0;
    for (int i = 0; i < `WAYS; i++) begin
      if (en[i] && !v[i] && !found) begin
        best = way_t'(i);
        found = 1'b1;
      end
    end
    for (int i = 0; i < `WAYS; i++) begin
      if (en[i] && !found && age[i] >= best_age) begin
        best = way_t'(i);
        best_age = age[i];
      end
    end
    return best;
  endfunction

  wire way_t victim =
    pick_victim(way_en, valid_r[s1_col], age_r[s1_col]);
  wire alloc_nxt = !cache_off && (|way_en);

  ////////////////////////////////////////////////////////////////////////
  // decode of the pipeline
  wire run       = state_r == ST_RUN;
  wire s1_live   = s1_v_r && run;
  wire fetch_hit = s1_live && !s1_r.we && !cache_off &&
                   cpu_lk.hit;
  wire go_busy   = s1_live && !fetch_hit;
  wire fill_go   = go_busy && !s1_r.we && alloc_nxt;   // victim retires
  wire acc       = cpu_req && cpu_ready_r;
  wire st_hit    = go_busy && s1_r.we && cpu_lk.hit;
  wire fill_ack  = state_r == ST_FILL && mem_ack;
  wire fill_last = fill_ack && (!alloc_r || dw_cnt_r == `LAST_DW);
  wire st_done   = state_r == ST_STORE && mem_ack;
  wire done      = fill_last || st_done;
  wire chan_hit  = chan_st && ch_lk.hit;
  wire ch_same   = chan_st && ch_tag == s1_tag && ch_col == s1_col;
  // a channel store to the block being filled, during the fill, leaves the block unkept
  wire fill_keep = fill_last && alloc_r && !stale_r && !ch_same;
  wire touch_en  = fetch_hit || st_hit || fill_keep;
  wire way_t touch_way = fill_keep ? fill_way_r : cpu_lk.way;

  wire [`IDX_W-1:0] rd_idx   = {s1_col, cpu_lk.way, s1_dw};
  wire [`IDX_W-1:0] fill_idx = {s1_col, fill_way_r, dw_cnt_r};
  wire [`DATA_W-1:0] rd_word = data_mem[rd_idx];

  // store data merged into the cached doubleword by byte enables
  logic [`DATA_W-1:0] st_merge;
  genvar b;
  generate
    for (b = 0; b < `BE_W; b++) begin : g_byte
      assign st_merge[b*8 +: 8] = s1_r.be[b] ? s1_r.wdata[b*8 +: 8]
                                             : rd_word[b*8 +: 8];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // data and address array writes; valid bits guard the unreset contents
  always_ff @(posedge clk) begin
    if (fill_ack && alloc_r) begin
      data_mem[fill_idx] <= mem_rdata;
    end else if (st_hit) begin
      data_mem[rd_idx] <= st_merge;
    end
  end

  always_ff @(posedge clk) begin
    if (fill_keep) begin
      tag_mem[s1_col][fill_way_r] <= s1_tag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // valid bits: program reset wins, then fill set, then channel clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < `COLS; c++) valid_r[c] <= '0;
    end else if (ipl_reset) begin
      for (int c = 0; c < `COLS; c++) valid_r[c] <= '0;
    end else begin
      // the victim is overwritten from the first ack on, so it drops now;
      // a fill left unkept by a channel store then leaves no mixed block
      if (fill_go) begin
        valid_r[s1_col][victim] <= 1'b0;
      end
      if (chan_hit) begin
        valid_r[ch_col][ch_lk.way] <= 1'b0;
      end
      if (fill_keep) begin
        valid_r[s1_col][fill_way_r] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lru ages: touched way becomes youngest, younger ones age by one
  // equal ages would stay equal until one is touched, so reset gives each way its own age
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < `COLS; c++) age_r[c] <= `AGE_INIT;
    end else if (touch_en) begin
      for (int i = 0; i < `WAYS; i++) begin
        if (way_t'(i) == touch_way) begin
          age_r[s1_col][i] <= '0;
        end else if (age_r[s1_col][i] < age_r[s1_col][touch_way]) begin
          age_r[s1_col][i] <= age_r[s1_col][i] + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request pipeline and storage sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r      <= ST_RUN;
      s1_r         <= '0;
      s1_v_r       <= 1'b0;
      sk_r         <= '0;
      sk_v_r       <= 1'b0;
      alloc_r      <= 1'b0;
      fill_way_r   <= '0;
      dw_cnt_r     <= '0;
      stale_r      <= 1'b0;
      cpu_ready_r  <= 1'b1;
      cpu_rvalid_r <= 1'b0;
      cpu_rdata_r  <= '0;
      mem_req_r    <= 1'b0;
      mem_we_r     <= 1'b0;
      mem_addr_r   <= '0;
      mem_wdata_r  <= '0;
      mem_be_r     <= '0;
    end else begin
      cpu_rvalid_r <= 1'b0;
      case (state_r)
        ST_RUN: begin
          if (fetch_hit) begin
            cpu_rvalid_r <= 1'b1;
            cpu_rdata_r  <= rd_word;
          end
          if (go_busy) begin
            // the request taken on this edge waits in the skid slot
            cpu_ready_r <= 1'b0;
            sk_v_r      <= acc;
            sk_r        <= in_req;
            mem_req_r   <= 1'b1;
            mem_we_r    <= s1_r.we;
            mem_wdata_r <= s1_r.wdata;
            stale_r     <= 1'b0;
            if (s1_r.we) begin
              state_r    <= ST_STORE;
              mem_be_r   <= s1_r.be;
              mem_addr_r <= {s1_r.addr[`TAG_HI:`DW_LO], 3'h0};
            end else begin
              state_r    <= ST_FILL;
              mem_be_r   <= {`BE_W{1'b1}};
              alloc_r    <= alloc_nxt;
              fill_way_r <= victim;
              dw_cnt_r   <= alloc_nxt ? 2'h0 : s1_dw;
              mem_addr_r <= {s1_r.addr[`TAG_HI:`BLK_LO],
                             alloc_nxt ? 2'h0 : s1_dw, 3'h0};
            end
          end else begin
            s1_v_r <= acc;
            s1_r   <= in_req;
          end
        end
        ST_FILL: begin
          if (ch_same) stale_r <= 1'b1;
          if (mem_ack) begin
            if (dw_cnt_r == s1_dw) begin
              cpu_rvalid_r <= 1'b1;
              cpu_rdata_r  <= mem_rdata;
            end
            dw_cnt_r <= dw_cnt_r + 2'h1;
            mem_addr_r[`DW_HI:`DW_LO] <= dw_cnt_r + 2'h1;
          end
        end
        ST_STORE: begin
        end
        default: state_r <= ST_RUN;
      endcase
      if (done) begin
        state_r     <= ST_RUN;
        mem_req_r   <= 1'b0;
        mem_we_r    <= 1'b0;
        cpu_ready_r <= 1'b1;
        s1_v_r      <= sk_v_r;
        s1_r        <= sk_r;
        sk_v_r      <= 1'b0;
      end
    end
  end

  assign cpu_ready  = cpu_ready_r;
  assign cpu_rvalid = cpu_rvalid_r;
  assign cpu_rdata  = cpu_rdata_r;
  assign mem_req    = mem_req_r;
  assign mem_we     = mem_we_r;
  assign mem_addr   = mem_addr_r;
  assign mem_wdata  = mem_wdata_r;
  assign mem_be     = mem_be_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic any_valid;   // helper: some block is valid
  always_comb begin
    any_valid = 1'b0;
    for (int c = 0; c < `COLS; c++) any_valid = any_valid | (|valid_r[c]);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_hit_lat;
    fetch_hit |=> cpu_rvalid && cpu_rdata == $past(rd_word);
  endproperty
  a_hit_lat: assert property (p_hit_lat)
    else $error("hit data not returned on time");

  property p_hit_nomem;
    fetch_hit |=> !mem_req && cpu_ready;
  endproperty
  a_hit_nomem: assert property (p_hit_nomem)
    else $error("hit reached storage");

  property p_miss_read;
    (go_busy && !s1_r.we) |=> mem_req && !mem_we && !cpu_ready;
  endproperty
  a_miss_read: assert property (p_miss_read)
    else $error("miss did not read storage");

  property p_write_thru;
    (go_busy && s1_r.we) |=> mem_req && mem_we &&
      mem_addr[`TAG_HI:`DW_LO] == $past(s1_r.addr[`TAG_HI:`DW_LO]);
  endproperty
  a_write_thru: assert property (p_write_thru)
    else $error("store not written through");

  property p_chan_inv;
    (chan_hit && !fill_keep && !ipl_reset) |=>
      !valid_r[$past(ch_col)][$past(ch_lk.way)];
  endproperty
  a_chan_inv: assert property (p_chan_inv)
    else $error("channel store left block valid");

  property p_off;
    (s1_live && !s1_r.we && cache_off) |=> mem_req && state_r == ST_FILL;
  endproperty
  a_off: assert property (p_off)
    else $error("disabled cache served a fetch");

  property p_row;
    fetch_hit |-> way_en[cpu_lk.way];
  endproperty
  a_row: assert property (p_row)
    else $error("hit in a disabled row");

  property p_ipl;
    ipl_reset |=> !any_valid;
  endproperty
  a_ipl: assert property (p_ipl)
    else $error("program reset left a valid block");

  property p_no_alloc;
    (go_busy && s1_r.we && !cpu_lk.hit) |=> state_r == ST_STORE;
  endproperty
  a_no_alloc: assert property (p_no_alloc)
    else $error("store miss started a fill");

  c_hit:   cover property (fetch_hit ##1 fetch_hit);
  c_fill:  cover property (fill_keep);
  c_inv:   cover property (chan_hit);
  c_sthit: cover property (st_hit);

endmodule

// ===== verification/stor_model.sv
// processor storage model behind the buffer cache
// assumes one request at a time, held steady until acked
`timescale 1ns/1ps
module stor_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [1:0]  lat,        // wait states before each ack
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [63:0] mem_wdata,
  input  wire logic [7:0]  mem_be,
  output logic             mem_ack,
  output logic [63:0]      mem_rdata
);
  logic [63:0] mem [logic [31:0]];     // only written doublewords
  logic [1:0]  wait_r;                 // wait states spent so far

  ////////////////////////////////////////////////////////////
  // unwritten storage holds a pattern made from its address
  function automatic logic [63:0] old(logic [31:0] a);
    return mem.exists(a) ? mem[a] : {a, ~a};
  endfunction
  function automatic logic [63:0] mrg(logic [63:0] o, n, logic [7:0] be);
    for (int b = 0; b < 8; b++) if (be[b]) o[8*b +: 8] = n[8*b +: 8];
    return o;
  endfunction

  ////////////////////////////////////////////////////////////
  // one ack pulse per request; data lines scramble when not acked
  // so the cache can never live on stale read data
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_ack   <= 1'b0;
      wait_r    <= 2'h0;
      mem_rdata <= 64'h0;
    end else if (mem_ack) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && wait_r < lat) begin
      wait_r    <= wait_r + 2'h1;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req) begin
      wait_r  <= 2'h0;
      mem_ack <= 1'b1;
      if (mem_we) mem[mem_addr] = mrg(old(mem_addr), mem_wdata, mem_be);
      else mem_rdata <= old(mem_addr);
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ===== verification/testbench.sv
// self-checking bench for the buffer cache with a storage model
// assumes 20 MHz clock, inputs driven at the falling edge
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  failures++; $display("CHECK FAILED at %0t: got %h want %h", \
  $time, g, e); end end
module testbench;
  typedef struct {logic [63:0] d; time t; bit h;} note_t;
  logic        clk, resetn, ipl_reset, size_16k, cache_off, chan_st;
  logic        cpu_req, cpu_we, cpu_ready, cpu_rvalid;
  logic        mem_req, mem_we, mem_ack;
  logic [1:0]  lat;                    // storage wait states
  logic [7:0]  row_off, cpu_be, mem_be;
  logic [31:0] cpu_addr, mem_addr, chan_addr;
  logic [63:0] cpu_wdata, cpu_rdata, mem_wdata, mem_rdata, wd;
  logic [20:0] t;                      // random tag base
  logic [5:0]  c;                      // random column base
  int          failures, comparisons, acks, i, m0;
  integer      seed;
  note_t       q[$];                   // expected fetch answers
  note_t       e;
  logic [63:0] sh [logic [31:0]];      // shadow of storage contents

  buffer_cache u_buffer_cache (.clk(clk), .resetn(resetn),
    .ipl_reset(ipl_reset), .size_16k(size_16k), .cache_off(cache_off),
    .row_off(row_off), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_be(cpu_be),
    .cpu_ready(cpu_ready), .cpu_rvalid(cpu_rvalid),
    .cpu_rdata(cpu_rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .chan_st(chan_st),
    .chan_addr(chan_addr));
  stor_model u_stor_model (.clk(clk), .resetn(resetn), .lat(lat),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  ////////////////////////////////////////////////////////////
  function automatic logic [63:0] mrg(logic [63:0] o, n, logic [7:0] be);
    for (int b = 0; b < 8; b++) if (be[b]) o[8*b +: 8] = n[8*b +: 8];
    return o;
  endfunction
  function automatic logic [63:0] rd(logic [31:0] x);
    return sh.exists(x) ? sh[x] : {x, ~x};
  endfunction
  // tag, column and doubleword into a byte address
  function automatic logic [31:0] ad(logic [20:0] tg, logic [5:0] cl,
                                     logic [1:0] d);
    return {tg, cl, d, 3'h0};
  endfunction
  task give_verdict;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // one request, left raised so hits can follow back to back
  task op(bit we, logic [31:0] x, logic [63:0] d, logic [7:0] be, bit h);
    cpu_req = 1'b1;
    cpu_we = we;
    cpu_addr = x;
    cpu_wdata = d;
    cpu_be = be;
    lat = 2'($random(seed));
    for (i = 0; i < 300 && cpu_ready !== 1'b1; i++) @(negedge clk);
    if (i == 300) begin failures++; give_verdict; end
    @(posedge clk);
    if (we) sh[x] = mrg(rd(x), d, be);
    else q.push_back('{rd(x), $time, h});
    @(negedge clk);
  endtask
  // go idle, wait for all answers, then count storage accesses
  task fin(int n0, int n);
    cpu_req = 1'b0;
    repeat (2) @(negedge clk);
    for (i = 0; i < 300 && !(q.size() == 0 && cpu_ready === 1'b1 &&
         mem_req === 1'b0); i++) @(negedge clk);
    if (i == 300) begin failures++; give_verdict; end
    `CHK(acks - n0, n)
  endtask
  task acc(bit we, logic [31:0] x, logic [63:0] d, logic [7:0] be,
           bit h, int n);
    int n0;
    n0 = acks;
    op(we, x, d, be, h);
    fin(n0, n);
  endtask
  task fe(logic [31:0] x, bit h, int n);
    acc(1'b0, x, 64'h0, 8'hff, h, n);
  endtask

  ////////////////////////////////////////////////////////////
  // clock: 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // watcher: oldest expected answer against each cpu_rvalid pulse
  always @(negedge clk) begin
    if (mem_ack === 1'b1) acks++;
    if (cpu_rvalid === 1'b1) begin
      if (q.size() == 0) begin
        failures++;
        $display("CHECK FAILED at %0t: unexpected answer", $time);
      end else begin
        e = q.pop_front();
        `CHK(cpu_rdata, e.d)
        if (e.h) `CHK($time - e.t, 64'd75)
      end
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h9e23;
    {failures, comparisons, acks} = '0;
    {resetn, ipl_reset, size_16k, cache_off, chan_st} = '0;
    {cpu_req, cpu_we, cpu_addr, cpu_wdata, cpu_be} = '0;
    {row_off, chan_addr, lat} = '0;
    repeat (3) @(negedge clk);
    `CHK(cpu_ready, 1'b1)
    `CHK(mem_req, 1'b0)
    resetn = 1'b1;
    t = 21'($random(seed));
    c = 6'($random(seed));
    fe(ad(t, c, 2'h2), 1'b0, 4);
    m0 = acks;
    for (int d = 0; d < 4; d++) op(1'b0, ad(t, c, d[1:0]), 64'h0, 8'hff, 1);
    fin(m0, 0);
    wd = {$random(seed), $random(seed)};
    acc(1'b1, ad(t, c, 2'h1), wd, 8'h3c, 1'b0, 1);
    fe(ad(t, c, 2'h1), 1'b1, 0);
    cache_off = 1'b1;
    fe(ad(t, c, 2'h1), 1'b0, 1);
    cache_off = 1'b0;
    acc(1'b1, ad(t + 21'h1, c, 2'h0), wd, 8'hff, 1'b0, 1);
    fe(ad(t + 21'h1, c, 2'h0), 1'b0, 4);
    chan_st = 1'b1;
    chan_addr = ad(t, c, 2'h3) | 32'h5;
    @(negedge clk);
    chan_st = 1'b0;
    fe(ad(t, c, 2'h0), 1'b0, 4);
    row_off = 8'hff;
    fe(ad(t, c, 2'h0), 1'b0, 1);
    row_off = 8'h00;
    fe(ad(t, c, 2'h0), 1'b1, 0);
    ipl_reset = 1'b1;
    @(negedge clk);
    ipl_reset = 1'b0;
    fe(ad(t, c, 2'h0), 1'b0, 4);
    // four ways of one column, then least recently used goes first
    for (int k = 0; k < 4; k++)
      fe(ad(t + 21'(k), c + 6'h1, 2'h0), 0, 4);
    fe(ad(t, c + 6'h1, 2'h1), 1'b1, 0);
    fe(ad(t + 21'h4, c + 6'h1, 2'h0), 1'b0, 4);
    fe(ad(t, c + 6'h1, 2'h2), 1'b1, 0);
    fe(ad(t + 21'h1, c + 6'h1, 2'h0), 1'b0, 4);
    // eight ways in the large size, all resident together
    size_16k = 1'b1;
    for (int k = 0; k < 8; k++)
      fe(ad(t + 21'(k), c + 6'h2, 2'h0), 0, 4);
    m0 = acks;
    for (int k = 0; k < 8; k++) op(1'b0, ad(t + 21'(k), c + 6'h2, 2'h3),
                                   64'h0, 8'hff, 1);
    fin(m0, 0);
    // a fetch taken as a store hit goes to storage waits in the skid slot
    m0 = acks;
    op(1'b1, ad(t, c + 6'h2, 2'h1), wd, 8'hff, 1'b0);
    op(1'b0, ad(t, c + 6'h2, 2'h1), 64'h0, 8'hff, 1'b0);
    fin(m0, 1);
    give_verdict;
  end
endmodule
